// [verilog/mcls_pkg.sv]
`default_nettype none
package mcls_pkg;
  localparam logic [7:0] MLC_OFFSET = 8'h04; // modem_line_control
  localparam logic [7:0] SLS_OFFSET = 8'h05; // serial_line_status
  localparam logic [7:0] MSR_OFFSET = 8'h06; // modem input state
  localparam logic [7:0] MLC_RESET = 8'h00;
  localparam logic [7:0] SLS_RESET = 8'h00;
  localparam int MLC_DTR = 0;
  localparam int MLC_RTS = 1;
  localparam int MLC_AUXA = 2;
  localparam int MLC_AUXB = 3;
  localparam int MLC_LOOP = 4;
  localparam int MLC_AFE = 5;
  localparam int MLC_HALF = 7;
  localparam int MSR_DCD = 7;
  localparam int MSR_RI = 6;
  localparam int MSR_DSR = 5;
  localparam int MSR_CTS = 4;

  // status inputs from the receive and transmit datapath
  typedef struct packed {
    logic rx_avail;
    logic overrun;
    logic parity_err;
    logic frame_err;
    logic break_det;
    logic thr_empty;
    logic tsr_empty;
    logic fifo_err;
    logic rx_at_trig;
  } line_stat_t;

  // modem pins seen from the device (active high levels as sampled)
  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic dcd;
  } modem_in_t;

  typedef struct packed {
    logic [7:0] mlc;
    logic [7:0] sls;
    logic [7:0] rdata;
    logic dtr;
    logic rts;
    logic aux_a;
    logic aux_b;
    logic tx_allow;
    logic loop_tx;
    logic half_stop;
    logic rts_hold;
  } mcls_state_t;
endpackage
`default_nettype wire

// [verilog/uart_modem_control_line_status.sv]
// Notes on behaviour
// - dtr pin high when bit0 zero
// - rts pin high when bit1 zero
// - loopback routes aux_out_a to ri path
// - loopback routes aux_out_b to dcd path
// - bit4 selects internal loopback mode
// - afe and bit1 enable auto rts/cts
// - afe alone enables only auto cts
// - afe clear disables all auto flow
// - afe clear: transmit echoed to receiver
// - bit7 selects half stop bit
// - status bit0 shows receive data present
// - status bit1 shows overrun
// - status bits2,3 parity and framing errors
// - status bit4 shows break
// - status bit5 holding register empty
// - status bit6 shift register empty
// - status bit7 any fifo error
// - modem status bit7 shows dcd path
`timescale 1ns/10ps
`default_nettype none
module uart_modem_control_line_status
  import mcls_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire line_stat_t LINE_STAT,
  input wire modem_in_t MODEM_IN,
  output logic DTR,
  output logic RTS,
  output logic AUX_OUT_A,
  output logic AUX_OUT_B,
  output logic TX_ALLOW,
  output logic LOOP_TX,
  output logic HALF_STOP
);
  mcls_state_t s_r, s_nxt;
  logic auto_cts, auto_rts, ri_path, dcd_path;

  // flow control decode and loopback input paths
  always_comb begin
    auto_cts = s_r.mlc[MLC_AFE];
    auto_rts = s_r.mlc[MLC_AFE] & s_r.mlc[MLC_RTS];
    ri_path = s_r.mlc[MLC_LOOP] ? s_r.mlc[MLC_AUXA] : MODEM_IN.ri;
    dcd_path = s_r.mlc[MLC_LOOP] ? s_r.mlc[MLC_AUXB] : MODEM_IN.dcd;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    if (WR && ADDR == MLC_OFFSET) begin
      s_nxt.mlc = WDATA & 8'hbf; // bit6 reserved reads zero
    end
    // status byte mirrors datapath state
    s_nxt.sls = {LINE_STAT.fifo_err,
                 LINE_STAT.tsr_empty,
                 LINE_STAT.thr_empty,
                 LINE_STAT.break_det,
                 LINE_STAT.frame_err,
                 LINE_STAT.parity_err,
                 LINE_STAT.overrun,
                 LINE_STAT.rx_avail};
    s_nxt.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        MLC_OFFSET: s_nxt.rdata = s_r.mlc;
        SLS_OFFSET: s_nxt.rdata = s_r.sls;
        MSR_OFFSET: begin
          s_nxt.rdata[MSR_DCD] = dcd_path;
          s_nxt.rdata[MSR_RI] = ri_path;
          s_nxt.rdata[MSR_DSR] = MODEM_IN.dsr;
          s_nxt.rdata[MSR_CTS] = MODEM_IN.cts;
        end
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // auto rts hold follows the trigger level flag, no hysteresis
    if (!auto_rts) begin
      s_nxt.rts_hold = 1'b0;
    end else if (LINE_STAT.rx_at_trig) begin
      s_nxt.rts_hold = 1'b1;
    end else begin
      s_nxt.rts_hold = 1'b0;
    end
    s_nxt.dtr = ~s_r.mlc[MLC_DTR];
    s_nxt.rts = auto_rts ? ~s_nxt.rts_hold : ~s_r.mlc[MLC_RTS];
    s_nxt.aux_a = s_r.mlc[MLC_LOOP] ? 1'b1 : ~s_r.mlc[MLC_AUXA];
    s_nxt.aux_b = s_r.mlc[MLC_LOOP] ? 1'b1 : ~s_r.mlc[MLC_AUXB];
    s_nxt.tx_allow = ~auto_cts | MODEM_IN.cts;
    s_nxt.loop_tx = s_r.mlc[MLC_LOOP] | ~s_r.mlc[MLC_AFE];
    s_nxt.half_stop = s_r.mlc[MLC_HALF];
  end

  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.mlc <= MLC_RESET;
      s_r.sls <= SLS_RESET;
      s_r.dtr <= 1'b1;
      s_r.rts <= 1'b1;
      s_r.aux_a <= 1'b1;
      s_r.aux_b <= 1'b1;
      s_r.tx_allow <= 1'b1;
      s_r.loop_tx <= 1'b1;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign RDATA = s_r.rdata;
  assign DTR = s_r.dtr;
  assign RTS = s_r.rts;
  assign AUX_OUT_A = s_r.aux_a;
  assign AUX_OUT_B = s_r.aux_b;
  assign TX_ALLOW = s_r.tx_allow;
  assign LOOP_TX = s_r.loop_tx;
  assign HALF_STOP = s_r.half_stop;

  // checks
  property p_dtr;
    @(posedge CLK) disable iff (!RST_N)
      CE |=> (DTR == ~$past(s_r.mlc[MLC_DTR]));
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr level wrong");

  property p_rts_manual;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !auto_rts) |=> (RTS == ~$past(s_r.mlc[MLC_RTS]));
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("rts manual wrong");

  property p_ri_loop;
    @(posedge CLK) disable iff (!RST_N)
      s_r.mlc[MLC_LOOP] |-> (ri_path == s_r.mlc[MLC_AUXA]);
  endproperty
  a_ri_loop: assert property (p_ri_loop) else $error("ri loop wrong");

  sequence s_msr_read;
    CE && RD && ADDR == MSR_OFFSET && s_r.mlc[MLC_LOOP];
  endsequence
  property p_dcd_loop;
    @(posedge CLK) disable iff (!RST_N)
      s_msr_read |=> (RDATA[MSR_DCD] == $past(s_r.mlc[MLC_AUXB]));
  endproperty
  a_dcd_loop: assert property (p_dcd_loop) else $error("dcd loop wrong");

  property p_cts_stall;
    @(posedge CLK) disable iff (!RST_N)
      (CE && s_r.mlc[MLC_AFE] && !MODEM_IN.cts) |=> !TX_ALLOW;
  endproperty
  a_cts_stall: assert property (p_cts_stall) else $error("cts stall missed");

  property p_no_flow;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !s_r.mlc[MLC_AFE]) |=> (TX_ALLOW && LOOP_TX);
  endproperty
  a_no_flow: assert property (p_no_flow) else $error("flow not off");

  property p_auto_rts;
    @(posedge CLK) disable iff (!RST_N)
      (CE && auto_rts && LINE_STAT.rx_at_trig) |=> !RTS;
  endproperty
  a_auto_rts: assert property (p_auto_rts) else $error("auto rts high");

  sequence s_sls_read;
    CE && RD && ADDR == SLS_OFFSET;
  endsequence
  property p_sls_read;
    @(posedge CLK) disable iff (!RST_N)
      s_sls_read |=> (RDATA == $past(s_r.sls));
  endproperty
  a_sls_read: assert property (p_sls_read) else $error("status read wrong");

  property p_half;
    @(posedge CLK) disable iff (!RST_N)
      CE |=> (HALF_STOP == $past(s_r.mlc[MLC_HALF]));
  endproperty
  a_half: assert property (p_half) else $error("half stop wrong");
endmodule // uart_modem_control_line_status
`default_nettype wire

// [sim/far_modem.sv]
`timescale 1ns/10ps
`default_nettype none
// remote modem: answers our dtr on dsr, gives cts unless held off
module far_modem
  import mcls_pkg::*;
(
  input wire logic DTR_PIN,
  input wire logic HOLD,
  input wire logic CARRIER,
  output modem_in_t MI
);
  // dtr is active low on the wire; ring never rings here
  assign MI = '{cts: !HOLD, dsr: !DTR_PIN, ri: 1'b0, dcd: CARRIER};
endmodule // far_modem
`default_nettype wire

// [sim/uart_modem_control_line_status_test.sv]
`timescale 1ns/10ps
`default_nettype none
module uart_modem_control_line_status_test
  import mcls_pkg::*;
;
  typedef struct packed {
    logic [7:0] mlc;
    logic hold;
    logic trig;
    logic [6:0] pins;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold = 1'b0;
  logic carrier = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] got;
  line_stat_t stat = '0;
  modem_in_t mi;
  logic dtr, rts, aux_a, aux_b, tx_allow, loop_tx, half_stop;
  int mismatches = 0;
  int total_checks = 0;
  wire [7:0] pins = {1'b0, dtr, rts, aux_a, aux_b, tx_allow, loop_tx,
    half_stop};
  // control byte, cts held off, fifo at trigger, expected pins
  row_t rows [10] = '{'{8'h00, 1'b0, 1'b0, 7'b1111110},
    '{8'h01, 1'b0, 1'b0, 7'b0111110}, '{8'h02, 1'b0, 1'b0, 7'b1011110},
    '{8'h0c, 1'b0, 1'b0, 7'b1100110}, '{8'h20, 1'b1, 1'b0, 7'b1111000},
    '{8'h22, 1'b0, 1'b1, 7'b1011100}, '{8'h22, 1'b1, 1'b0, 7'b1111000},
    '{8'h02, 1'b1, 1'b1, 7'b1011110}, '{8'h80, 1'b0, 1'b0, 7'b1111111},
    '{8'h1c, 1'b0, 1'b0, 7'b1111110}};
  // free running clock
  always #4 clk = ~clk;
  uart_modem_control_line_status u_dut (.CLK(clk), .RST_N(rst_n),
    .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LINE_STAT(stat), .MODEM_IN(mi), .DTR(dtr), .RTS(rts),
    .AUX_OUT_A(aux_a), .AUX_OUT_B(aux_b), .TX_ALLOW(tx_allow),
    .LOOP_TX(loop_tx), .HALF_STOP(half_stop));
  far_modem u_far (.DTR_PIN(dtr), .HOLD(hold), .CARRIER(carrier),
    .MI(mi));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // settle, one read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a);
    repeat (3) @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 chk(pins, 8'h7e);
    chk(rdata, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(MLC_OFFSET);
    chk(got, MLC_RESET);
    rd_reg(SLS_OFFSET);
    chk(got, SLS_RESET);
    foreach (rows[i]) begin
      wr_reg(MLC_OFFSET, rows[i].mlc);
      hold <= rows[i].hold;
      stat.rx_at_trig <= rows[i].trig;
      repeat (3) @(posedge clk);
      #1 chk(pins, {1'b0, rows[i].pins});
      @(posedge clk);
    end
    rd_reg(MSR_OFFSET);
    chk(got & 8'hc0, 8'hc0);
    wr_reg(MLC_OFFSET, 8'h10);
    rd_reg(MSR_OFFSET);
    chk(got & 8'hc0, 8'h00);
    carrier <= 1'b1;
    wr_reg(MLC_OFFSET, 8'hef);
    wr_reg(SLS_OFFSET, 8'hff);
    rd_reg(MLC_OFFSET);
    chk(got, 8'haf);
    rd_reg(MSR_OFFSET);
    chk(got & 8'h80, 8'h80);
    rd_reg(8'h09);
    chk(got, 8'h00);
    for (int i = 0; i < 8; i++) begin
      stat <= line_stat_t'(9'h100 >> i);
      rd_reg(SLS_OFFSET);
      chk(got, 8'h01 << i);
    end
    print_verdict();
  end
endmodule // uart_modem_control_line_status_test
`default_nettype wire
